// ==== scr_config_regs.sv ====
// module: system configuration register bank with AXI4-Lite access
// Contract
// - pointer low nibble picks expanded group, high nibble picks working group
// - three configuration registers live in group F only; others reserved
// - config bit 0 routes comparator outputs onto port3 pins 4 and 7
// - config bit 1: port 1 open-drain when zero, push-pull when one
// - config bit 2: port 0 open-drain when zero, push-pull when one
// - config bits 3..6: ports 0..3 reduced-noise when zero, standard when one
// - config bit 7 selects oscillator drive; clock ratio unchanged; resets one
// - stop-recovery register write-only except read-only bit 7
// - bit 7 set on stop recovery, cleared only by power-on
// - stop-recovery bit 6 picks wake level polarity
// - stop-recovery bit 5 picks reset delay after recovery
// - stop-recovery bits 2..4 encode the wake source
// - stop-recovery register decodes at location 0BH in group F
// - watchdog mode locks after fixed cycles counted from the first instruction after any reset
// - watchdog mode write-only at location 0FH in group F
// - global reset driven while supply is below threshold
// - program modes decoded from pins; option bits at address 63
// - stop recovery keeps watchdog mode and stop-recovery contents
`timescale 1ns/100ps
`default_nettype none
module scr_config_regs
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic power_on,
    input wire logic watchdog_reset,
    input wire logic stop_recovered,
    input wire logic first_instr,
    input wire logic supply_low,
    input wire logic mode_sel_pin,
    input wire logic chip_en_n_pin,
    input wire logic out_en_n_pin,
    input wire logic program_strobe_n_pin,
    input wire logic [5:0] prog_addr_pin,
    input wire logic [scr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [scr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [3:0] expanded_group,
    output logic [3:0] working_group,
    output logic comp_to_port3,
    output logic port1_push_pull,
    output logic port0_push_pull,
    output logic [3:0] port_std_drive,
    output logic osc_std_drive,
    output logic recovery_level,
    output logic recovery_delay,
    output logic [2:0] recovery_source,
    output logic [7:0] watchdog_mode,
    output logic watchdog_locked,
    output logic global_reset,
    output logic prog_read,
    output logic prog_write,
    output logic prog_option
);
    import scr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [9:0] pin_meta_q;
    logic [9:0] pin_sync_q;
    logic [9:0] pin_raw;
    assign pin_raw = {prog_addr_pin, program_strobe_n_pin, out_en_n_pin, chip_en_n_pin, mode_sel_pin};

    always_ff @(posedge core_clk)
    begin
        pin_meta_q <= pin_raw;
        pin_sync_q <= pin_meta_q;
    end

    logic supply_meta_q;
    logic supply_sync_q;
    always_ff @(posedge core_clk)
    begin
        supply_meta_q <= supply_low;
        supply_sync_q <= supply_meta_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // write channel
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic w_lane0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;

    wire aw_take = s_axi_awvalid && !aw_held_q && !bvalid_q;
    wire w_take = s_axi_wvalid && !w_held_q && !bvalid_q;
    wire aw_have = aw_held_q || aw_take;
    wire w_have = w_held_q || w_take;
    wire wr_fire = aw_have && w_have && !bvalid_q;
    wire [ADDR_W-1:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    wire [7:0] wr_byte = w_held_q ? w_data_q[7:0] : s_axi_wdata[7:0];
    wire wr_lane0 = w_held_q ? w_lane0_q : s_axi_wstrb[0];
    wire wr_bank = wr_addr[7:6] == ADDR_BANK_BASE[7:6];
    wire wr_map = (wr_addr == ADDR_REG_POINTER) || (wr_addr == ADDR_STATUS) || wr_bank;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_lane0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                aw_addr_q <= s_axi_awaddr;
            if (w_take)
            begin
                w_data_q <= s_axi_wdata;
                w_lane0_q <= s_axi_wstrb[0];
            end
            aw_held_q <= wr_fire ? 1'b0 : aw_have;
            w_held_q <= wr_fire ? 1'b0 : w_have;
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // expanded register decode
    logic [7:0] reg_pointer_q;
    logic [7:0] port_osc_cfg_q;
    logic [6:0] stop_recovery_q;
    logic stop_flag_q;
    logic [7:0] watchdog_mode_q;
    logic [6:0] lock_cnt_q;
    logic locked_q;

    wire grp_f = reg_pointer_q[3:0] == ERF_GROUP_CFG[3:0];
    wire wr_port_oscillator_config = wr_fire && wr_lane0 && wr_bank && grp_f && wr_addr[5:2] == LOC_PORT_OSC_CFG;
    wire wr_smr = wr_fire && wr_lane0 && wr_bank && grp_f && wr_addr[5:2] == LOC_STOP_RECOVERY;
    wire wr_wdm = wr_fire && wr_lane0 && wr_bank && grp_f && wr_addr[5:2] == LOC_WATCHDOG_MODE;
    wire wr_rp = wr_fire && wr_lane0 && wr_addr == ADDR_REG_POINTER;
    wire any_reset = power_on || watchdog_reset || stop_recovered;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            reg_pointer_q <= REG_POINTER_RST;
            port_osc_cfg_q <= PORT_OSC_CFG_RST | 8'h80;
        end
        else
        begin
            if (wr_rp)
                reg_pointer_q <= wr_byte;
            if (wr_port_oscillator_config)
                port_osc_cfg_q <= wr_byte;
        end
    end

    // stop-recovery and watchdog mode survive a stop recovery
    always_ff @(posedge core_clk)
    begin
        if (power_on)
        begin
            stop_recovery_q <= STOP_RECOVERY_RST[6:0];
            stop_flag_q <= 1'b0;
            watchdog_mode_q <= WATCHDOG_MODE_RST;
        end
        else
        begin
            if (wr_smr)
                stop_recovery_q <= wr_byte[6:0];
            if (stop_recovered)
                stop_flag_q <= 1'b1;
            if (wr_wdm && !locked_q)
                watchdog_mode_q <= wr_byte;
        end
    end

    // lock counter restarts on every reset kind, runs from first instruction
    logic counting_q;
    always_ff @(posedge core_clk)
    begin
        if (!resetn || any_reset)
        begin
            lock_cnt_q <= '0;
            locked_q <= 1'b0;
            counting_q <= 1'b0;
        end
        else
        begin
            if (first_instr)
                counting_q <= 1'b1;
            if ((counting_q || first_instr) && !locked_q)
            begin
                if (lock_cnt_q == 7'(WDM_LOCK_CYCLES - 1))
                    locked_q <= 1'b1;
                else
                    lock_cnt_q <= lock_cnt_q + 7'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    wire ar_take = s_axi_arvalid && !rvalid_q;
    wire rd_bank = s_axi_araddr[7:6] == ADDR_BANK_BASE[7:6];
    wire rd_smr = rd_bank && grp_f && s_axi_araddr[5:2] == LOC_STOP_RECOVERY;
    wire rd_port_oscillator_config = rd_bank && grp_f && s_axi_araddr[5:2] == LOC_PORT_OSC_CFG;
    wire rd_rp = s_axi_araddr == ADDR_REG_POINTER;
    wire rd_stat = s_axi_araddr == ADDR_STATUS;
    wire rd_map = rd_rp || rd_stat || rd_bank;
    wire [31:0] rd_word = rd_rp ? {24'h000000, reg_pointer_q} :
                          rd_port_oscillator_config ? {24'h000000, port_osc_cfg_q} :
                          rd_smr ? {24'h000000, stop_flag_q, 7'h00} :
                          rd_stat ? {30'h00000000, locked_q, stop_flag_q} :
                          UNMAPPED_READ;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // programming mode decode
    wire p_mode = pin_sync_q[0];
    wire p_ce_n = pin_sync_q[1];
    wire p_oe_n = pin_sync_q[2];
    wire p_pgm_n = pin_sync_q[3];
    wire [5:0] p_addr = pin_sync_q[9:4];
    wire dec_read = p_mode && !p_ce_n && !p_oe_n && p_pgm_n;
    wire dec_prog = p_mode && !p_ce_n && p_oe_n && !p_pgm_n;
    wire dec_opt = (dec_read || dec_prog) && p_addr == OPTION_ADDR;

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            prog_read <= 1'b0;
            prog_write <= 1'b0;
            prog_option <= 1'b0;
            global_reset <= 1'b1;
        end
        else
        begin
            prog_read <= dec_read;
            prog_write <= dec_prog;
            prog_option <= dec_opt;
            global_reset <= supply_sync_q;
        end
    end

    always_ff @(posedge core_clk)
    begin
        expanded_group <= reg_pointer_q[3:0];
        working_group <= reg_pointer_q[7:4];
        comp_to_port3 <= port_osc_cfg_q[CFG_COMP_OUT];
        port1_push_pull <= port_osc_cfg_q[CFG_P1_PUSHPULL];
        port0_push_pull <= port_osc_cfg_q[CFG_P0_PUSHPULL];
        port_std_drive <= port_osc_cfg_q[CFG_STD_DRIVE_LO+3:CFG_STD_DRIVE_LO];
        osc_std_drive <= port_osc_cfg_q[CFG_OSC_STD];
        recovery_level <= stop_recovery_q[SR_LEVEL];
        recovery_delay <= stop_recovery_q[SR_DELAY];
        recovery_source <= stop_recovery_q[SR_SRC_HI:SR_SRC_LO];
        watchdog_mode <= watchdog_mode_q;
        watchdog_locked <= locked_q;
    end

    assign s_axi_awready = aw_take;
    assign s_axi_wready = w_take;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ar_take;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule
`default_nettype wire

// ==== scr_config_regs_chk.sv ====
// concurrent checks on the configuration register bank ports
`timescale 1ns/100ps
`default_nettype none
module scr_chk
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic power_on,
    input wire logic supply_low,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comp_to_port3,
    input wire logic [3:0] port_std_drive,
    input wire logic osc_std_drive,
    input wire logic [7:0] watchdog_mode,
    input wire logic watchdog_locked,
    input wire logic global_reset,
    input wire logic prog_read,
    input wire logic prog_write
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response missing");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while pending");
    chk_cfg_reset: assert property ($rose(resetn) |=> !comp_to_port3 && osc_std_drive && port_std_drive == 4'hF)
        else $error("config reset value wrong");
    chk_supply_reset: assert property ($stable(supply_low) [*4] |-> global_reset == supply_low)
        else $error("global reset not following supply");
    chk_lock_freeze: assert property (watchdog_locked && $past(watchdog_locked) && !$past(power_on) && !$past(power_on, 2)
        |-> $stable(watchdog_mode))
        else $error("watchdog mode changed after lock");
    chk_prog_excl: assert property (!(prog_read && prog_write))
        else $error("read and program decoded together");
endmodule
bind scr_config_regs scr_chk u_chk (.*);
`default_nettype wire

// ==== scr_pkg.sv ====
// package: constants for the system configuration register bank
package scr_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] ERF_GROUP_CFG = 8'h0F;
    localparam logic [3:0] LOC_PORT_OSC_CFG = 4'h0;
    localparam logic [3:0] LOC_STOP_RECOVERY = 4'hB;
    localparam logic [3:0] LOC_WATCHDOG_MODE = 4'hF;
    localparam logic [7:0] ADDR_REG_POINTER = 8'h00;
    localparam logic [7:0] ADDR_BANK_BASE = 8'h40;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] PORT_OSC_CFG_RST = 8'hFE;
    localparam logic [7:0] STOP_RECOVERY_RST = 8'h00;
    localparam logic [7:0] WATCHDOG_MODE_RST = 8'h00;
    localparam logic [7:0] REG_POINTER_RST = 8'h00;
    localparam int unsigned CFG_COMP_OUT = 0;
    localparam int unsigned CFG_P1_PUSHPULL = 1;
    localparam int unsigned CFG_P0_PUSHPULL = 2;
    localparam int unsigned CFG_STD_DRIVE_LO = 3;
    localparam int unsigned CFG_OSC_STD = 7;
    localparam int unsigned SR_FLAG = 7;
    localparam int unsigned SR_LEVEL = 6;
    localparam int unsigned SR_DELAY = 5;
    localparam int unsigned SR_SRC_LO = 2;
    localparam int unsigned SR_SRC_HI = 4;
    localparam int unsigned WDM_LOCK_CYCLES = 64;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [1:0] PMODE_NONE = 2'b00;
    localparam logic [1:0] PMODE_READ = 2'b01;
    localparam logic [1:0] PMODE_PROGRAM = 2'b10;
    localparam logic [5:0] OPTION_ADDR = 6'd63;
endpackage

// ==== scr_prog_model.sv ====
// programmer model driving the programming mode pins
`timescale 1ns/100ps
`default_nettype none
module scr_prog_model
#(
    parameter int PULSE_CYC = 40000,
    parameter int OPT_PULSE_CYC = 116000
)
(
    input wire logic core_clk,
    input wire logic [1:0] pcmd,
    input wire logic [5:0] paddr,
    output logic mode_sel_pin,
    output logic chip_en_n_pin,
    output logic out_en_n_pin,
    output logic program_strobe_n_pin,
    output logic [5:0] prog_addr_pin
);
    int cnt = 0;
    // every pin always at a defined level, idle included
    assign prog_addr_pin = paddr;
    assign mode_sel_pin = pcmd != 2'b00;
    assign chip_en_n_pin = pcmd == 2'b00;
    assign out_en_n_pin = pcmd != 2'b01;
    // one pulse per program command: 1 ms normal, 2.9 ms option, at 25 ns
    assign program_strobe_n_pin = !(pcmd == 2'b10 && cnt < ((paddr == 6'd63) ? OPT_PULSE_CYC : PULSE_CYC));
    always @(posedge core_clk)
        cnt <= (pcmd == 2'b10) ? cnt + 1 : 0;
endmodule
`default_nettype wire

// ==== tb.sv ====
// testbench for the configuration register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    import scr_pkg::*;
    localparam logic [7:0] A_SR = ADDR_BANK_BASE + {2'b00, LOC_STOP_RECOVERY, 2'b00};
    localparam logic [7:0] A_WD = ADDR_BANK_BASE + {2'b00, LOC_WATCHDOG_MODE, 2'b00};
    // no external oscillator is fed, so the reduced-noise clock limit is kept
    localparam int EXT_CLK_KHZ = 4000;
    logic core_clk = 1'b0, resetn = 1'b0, power_on = 1'b1, watchdog_reset = 1'b0;
    logic stop_recovered = 1'b0, first_instr = 1'b0, supply_low = 1'b0;
    logic [1:0] pcmd = 2'b00;
    logic [5:0] paddr = 6'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q, d;
    logic [3:0] s_axi_wstrb = 4'hF, expanded_group, working_group, port_std_drive;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic mode_sel_pin, chip_en_n_pin, out_en_n_pin, program_strobe_n_pin;
    logic [5:0] prog_addr_pin;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic comp_to_port3, port1_push_pull, port0_push_pull, osc_std_drive, recovery_level, recovery_delay;
    logic [2:0] recovery_source;
    logic [7:0] watchdog_mode, cfg_m = PORT_OSC_CFG_RST, wdm_m;
    logic watchdog_locked, global_reset, prog_read, prog_write, prog_option, flag_m = 1'b0;
    int failures = 0;
    int cmp_count = 0;
    int seed = 84347;
    wire logic [7:0] cfg_o = {osc_std_drive, port_std_drive, port0_push_pull, port1_push_pull, comp_to_port3};
    wire logic [4:0] sr_o = {recovery_level, recovery_delay, recovery_source};

    scr_config_regs uut (.*);
    scr_prog_model #(.PULSE_CYC(40000)) u_prog (.*);

    always #12.5 core_clk = ~core_clk;
    ////////////////////////////////////////
    task automatic final_report();
        if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // one transfer; ready raised on the edge the answer appears, so the slave never has to hold it
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] dd = 32'h0, input logic [3:0] sb = 4'hF);
        logic done, ta, tw, tr;
        done = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= dd;
        s_axi_wstrb <= sb;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(negedge core_clk);
            done = (w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready) === 1'b1;
            ta = s_axi_awready === 1'b1;
            tw = s_axi_wready === 1'b1;
            tr = s_axi_arready === 1'b1;
            q = s_axi_rdata;
            r = w ? s_axi_bresp : s_axi_rresp;
            @(posedge core_clk);
            s_axi_awvalid <= s_axi_awvalid && !ta;
            s_axi_wvalid <= s_axi_wvalid && !tw;
            s_axi_arvalid <= s_axi_arvalid && !tr;
            s_axi_bready <= w && !done;
            s_axi_rready <= !w && !done;
        end
        if (!done)
        begin
            failures++;
            final_report();
        end
        @(negedge core_clk);
    endtask

    // 0 first instruction, 1 stop recovery, 2 power-on, 3 watchdog reset
    task automatic pulse(input int k);
        @(posedge core_clk);
        first_instr <= k == 0;
        stop_recovered <= k == 1;
        power_on <= k == 2;
        watchdog_reset <= k == 3;
        @(posedge core_clk);
        first_instr <= 1'b0;
        stop_recovered <= 1'b0;
        power_on <= 1'b0;
        watchdog_reset <= 1'b0;
        repeat (2) @(negedge core_clk);
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        power_on <= 1'b0;
        @(negedge core_clk);
        check(cfg_o, cfg_m);
        axi(1'b1, ADDR_REG_POINTER, 32'h3F);
        check({working_group, expanded_group}, 8'h3F);
        axi(1'b0, ADDR_BANK_BASE);
        check(q, {24'h0, cfg_m});
        repeat (8)
        begin
            d = $random(seed);
            axi(1'b1, ADDR_BANK_BASE, d, 4'($random(seed)) | 4'(d[0]));
            cfg_m = s_axi_wstrb[0] ? d[7:0] : cfg_m;
            check(cfg_o, cfg_m);
            axi(1'b0, ADDR_BANK_BASE);
            check(q, {24'h0, cfg_m});
        end
        axi(1'b1, ADDR_REG_POINTER, 32'h30);
        axi(1'b1, ADDR_BANK_BASE, {24'h0, ~cfg_m});
        check(cfg_o, cfg_m);
        axi(1'b1, ADDR_REG_POINTER, 32'h0F);
        axi(1'b1, ADDR_BANK_BASE + 8'h04, 32'hFF);
        check(r, RESP_OKAY);
        axi(1'b0, ADDR_BANK_BASE + 8'h04);
        check(q, UNMAPPED_READ);
        axi(1'b0, 8'h80);
        check(r, RESP_SLVERR);
        wdm_m = 8'hA5;
        axi(1'b1, A_WD, {24'h0, wdm_m});
        check(watchdog_mode, wdm_m);
        axi(1'b0, A_WD);
        check(q, 32'h0);
        pulse(0);
        repeat (WDM_LOCK_CYCLES + 4) @(negedge core_clk);
        check(watchdog_locked, 1'b1);
        axi(1'b1, A_WD, 32'h5A);
        check(watchdog_mode, wdm_m);
        pulse(3);
        check(watchdog_locked, 1'b0);
        wdm_m = 8'h5A;
        axi(1'b1, A_WD, {24'h0, wdm_m});
        check(watchdog_mode, wdm_m);
        d = $random(seed);
        axi(1'b1, A_SR, d);
        check(sr_o, d[6:2]);
        axi(1'b0, A_SR);
        check(q, 32'h0);
        pulse(1);
        flag_m = 1'b1;
        check(sr_o, d[6:2]);
        check(watchdog_mode, wdm_m);
        axi(1'b0, ADDR_STATUS);
        check(q[1:0], {1'b0, flag_m});
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        cfg_m = PORT_OSC_CFG_RST;
        repeat (2) @(negedge core_clk);
        check(cfg_o, cfg_m);
        check({working_group, expanded_group}, REG_POINTER_RST);
        axi(1'b1, ADDR_REG_POINTER, 32'h0F);
        axi(1'b0, A_SR);
        check(q, {24'h0, flag_m, 7'h0});
        pulse(2);
        flag_m = 1'b0;
        axi(1'b0, A_SR);
        check(q, {24'h0, flag_m, 7'h0});
        check(watchdog_mode, WATCHDOG_MODE_RST);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge core_clk);
            supply_low <= i[0];
            repeat (5) @(negedge core_clk);
            check(global_reset, supply_low);
        end
        for (int i = 0; i < 6; i++)
        begin
            @(posedge core_clk);
            pcmd <= 2'(i % 3);
            paddr <= (i == 1 || i == 3) ? 6'd63 : 6'(i);
            repeat (6) @(negedge core_clk);
            check({prog_option, prog_write, prog_read}, {pcmd != 2'd0 && paddr == OPTION_ADDR, pcmd == 2'd2, pcmd == 2'd1});
            // let a program pulse run to its full width before the next mode
            for (int n = 0; n < 50000 && program_strobe_n_pin !== 1'b1; n++)
                @(negedge core_clk);
            if (program_strobe_n_pin !== 1'b1)
            begin
                failures++;
                final_report();
            end
        end
        final_report();
    end
endmodule
`default_nettype wire
